// ===== hw/ibdsw_top.sv
`timescale 1ns/1ps
`default_nettype none
module ibdsw_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ibdsw_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ibdsw_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ibdsw_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [ibdsw_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic far_link_up,
  output logic internal_irq,
  output logic external_irq,
  output ibdsw_pkg::ibdsw_msg_t irq_msg,
  input wire logic chk_valid,
  input wire ibdsw_pkg::ibdsw_chk_req_t chk_req,
  output logic chk_done,
  output ibdsw_pkg::ibdsw_chk_res_t chk_res
);
  import ibdsw_pkg::*;

  ibdsw_state_t st;
  ibdsw_state_t next_st;
  logic [1:0] lvl;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [DATA_W-1:0] byte_mask(input logic [3:0] strb);
    logic [DATA_W-1:0] m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{strb[i]}};
    end
    return m;
  endfunction

  // Window can stand on its own as a claiming range
  function automatic logic win_active(input ibdsw_state_t s, input logic side, input int w);
    logic a;
    a = 1'b0;
    if (!side) begin
      unique case (w)
        0, 1: begin
          a = 1'b0;
        end
        2, 3, 4: begin
          a = s.setup[0][w][SETUP_EN];
        end
        default: begin
          a = 1'b0;
        end
      endcase
    end else begin
      unique case (w)
        0: begin
          a = 1'b1;
        end
        1: begin
          a = s.setup[1][1][SETUP_EN];
        end
        2, 4: begin
          a = s.setup[1][w][SETUP_EN];
        end
        default: begin
          a = 1'b0;
        end
      endcase
    end
    return a;
  endfunction

  // Only these even windows may pair with their odd neighbour
  function automatic logic win_pairs(input logic side, input int w);
    return (!side && w == 4) || (side && (w == 2 || w == 4));
  endfunction

  function automatic logic win_is64(input ibdsw_state_t s, input logic side, input int w);
    return win_pairs(side, w) && s.setup[side][w][SETUP_64];
  endfunction

  // Returns {hit, inside_limit}
  function automatic logic [1:0] win_eval(input ibdsw_state_t s, input logic side,
                                          input int w, input logic [63:0] addr);
    logic [SETUP_SZ_W-1:0] n;
    logic [DATA_W-1:0] m;
    logic [DATA_W-1:0] upper;
    logic hit;
    logic inlim;
    int nxt;
    // Fixed CSR windows ignore the size field
    if (side && w < 2) begin
      n = CSR_WIN_LOG2;
    end else begin
      n = s.setup[side][w][SETUP_SZ_LSB +: SETUP_SZ_W];
    end
    m = 32'hFFFF_FFFF << n;
    // Upper base sits in the odd neighbour; clamp keeps the index in range
    nxt = (w < NUM_WIN - 1) ? w + 1 : w;
    upper = win_is64(s, side, w) ? s.base[side][nxt] : 32'h0000_0000;
    hit = win_active(s, side, w) && (addr[63:32] == upper) &&
          ((addr[31:0] & m) == (s.base[side][w] & m));
    inlim = 1'b1;
    if (!(side && w < 2) && s.setup[side][w][SETUP_LIM]) begin
      inlim = addr[31:0] <= s.limit[side][w];
    end
    return {hit, inlim};
  endfunction

  // ****************************************************************
  // Doorbell levels
  // ****************************************************************
  always_comb begin
    // Internal side goes quiet while the far link is down
    lvl[0] = (|(st.req[0] & ~st.mask[0])) && st.link_up;
    lvl[1] = |(st.req[1] & ~st.mask[1]);
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic [ADDR_W-1:0] a;
    logic [DATA_W-1:0] bm;
    logic [DATA_W-1:0] bits;
    logic [1:0] ev;
    logic found;
    logic ok;
    logic ws;
    logic [2:0] wi;
    logic [1:0] wd;
    logic db_side;
    a = '0;
    bm = '0;
    bits = '0;
    ev = '0;
    found = 1'b0;
    ok = 1'b0;
    ws = 1'b0;
    wi = '0;
    wd = '0;
    db_side = 1'b0;
    next_st = st;

    // Link status synchroniser; a change counts once stages two and three agree
    next_st.lsync = {st.lsync[1:0], far_link_up};
    if (st.lsync[1] == st.lsync[2]) begin
      next_st.link_up = st.lsync[2];
    end

    // Write address and data are taken independently
    if (s_axi_awvalid && s_axi_awready) begin
      next_st.aw_got = 1'b1;
      next_st.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_st.w_got = 1'b1;
      next_st.wdata = s_axi_wdata;
      next_st.wstrb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end

    // ****************************************************************
    // Register write; view bit ignored so both sides see one map
    // ****************************************************************
    if (st.aw_got && st.w_got && !st.bvalid) begin
      a = st.awaddr;
      a[VIEW_BIT] = 1'b0;
      bm = byte_mask(st.wstrb);
      bits = st.wdata & bm;
      ok = 1'b1;
      db_side = a[4];
      if (a[1:0] != 2'h0) begin
        ok = 1'b0;
      end else if (a[WIN_BLK_BIT]) begin
        ws = a[WIN_SIDE_BIT];
        wi = a[WIN_IDX_LSB +: 3];
        wd = a[3:2];
        if (wi < 3'h6 && wd != 2'h3) begin
          unique case (wd)
            WIN_WORD_SETUP: begin
              next_st.setup[ws][wi] = (st.setup[ws][wi] & ~bm) | bits;
              if (!win_pairs(ws, int'(wi))) begin
                next_st.setup[ws][wi][SETUP_64] = 1'b0;
              end
            end
            WIN_WORD_BASE: begin
              next_st.base[ws][wi] = (st.base[ws][wi] & ~bm) | bits;
            end
            default: begin
              next_st.limit[ws][wi] = (st.limit[ws][wi] & ~bm) | bits;
            end
          endcase
        end else begin
          ok = 1'b0;
        end
      end else if (a < OFS_INT_REQ_SET) begin
        next_st.scratch[a[4:2]] = (st.scratch[a[4:2]] & ~bm) | bits;
      end else if (a == OFS_INT_REQ_SET || a == OFS_EXT_REQ_SET) begin
        next_st.req[db_side] = st.req[db_side] | bits[DB_W-1:0];
      end else if (a == OFS_INT_REQ_CLR || a == OFS_EXT_REQ_CLR) begin
        next_st.req[db_side] = st.req[db_side] & ~bits[DB_W-1:0];
      end else if (a == OFS_INT_MASK_SET || a == OFS_EXT_MASK_SET) begin
        next_st.mask[db_side] = st.mask[db_side] | bits[DB_W-1:0];
      end else if (a == OFS_INT_MASK_CLR || a == OFS_EXT_MASK_CLR) begin
        next_st.mask[db_side] = st.mask[db_side] & ~bits[DB_W-1:0];
      end else if (a == OFS_CTRL) begin
        next_st.ctrl = ((st.ctrl & ~bm) | bits) & CTRL_IMPL;
      end else if (a != OFS_STATUS) begin
        ok = 1'b0;
      end
      next_st.aw_got = 1'b0;
      next_st.w_got = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = ok ? RESP_OKAY : RESP_SLVERR;
    end

    // ****************************************************************
    // Register read
    // ****************************************************************
    if (s_axi_rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      a = s_axi_araddr;
      a[VIEW_BIT] = 1'b0;
      next_st.rvalid = 1'b1;
      next_st.rdata = '0;
      next_st.rresp = RESP_OKAY;
      if (a[1:0] != 2'h0) begin
        next_st.rresp = RESP_SLVERR;
      end else if (a[WIN_BLK_BIT]) begin
        ws = a[WIN_SIDE_BIT];
        wi = a[WIN_IDX_LSB +: 3];
        wd = a[3:2];
        if (wi < 3'h6 && wd == WIN_WORD_SETUP) begin
          next_st.rdata = st.setup[ws][wi];
        end else if (wi < 3'h6 && wd == WIN_WORD_BASE) begin
          next_st.rdata = st.base[ws][wi];
        end else if (wi < 3'h6 && wd == WIN_WORD_LIMIT) begin
          next_st.rdata = st.limit[ws][wi];
        end else begin
          next_st.rresp = RESP_SLVERR;
        end
      end else if (a < OFS_INT_REQ_SET) begin
        next_st.rdata = st.scratch[a[4:2]];
      end else if (a == OFS_INT_REQ_SET || a == OFS_INT_REQ_CLR) begin
        // Set and clear points read the same register
        next_st.rdata = {16'h0000, st.req[0]};
      end else if (a == OFS_EXT_REQ_SET || a == OFS_EXT_REQ_CLR) begin
        next_st.rdata = {16'h0000, st.req[1]};
      end else if (a == OFS_INT_MASK_SET || a == OFS_INT_MASK_CLR) begin
        next_st.rdata = {16'h0000, st.mask[0]};
      end else if (a == OFS_EXT_MASK_SET || a == OFS_EXT_MASK_CLR) begin
        next_st.rdata = {16'h0000, st.mask[1]};
      end else if (a == OFS_CTRL) begin
        next_st.rdata = st.ctrl;
      end else if (a == OFS_STATUS) begin
        next_st.rdata[STAT_INT_LVL] = lvl[0];
        next_st.rdata[STAT_EXT_LVL] = lvl[1];
        next_st.rdata[STAT_LINK_UP] = st.link_up;
      end else begin
        next_st.rresp = RESP_SLVERR;
      end
    end

    // ****************************************************************
    // Interrupt messages
    // ****************************************************************
    // INTx reports both edges of a level, MSI only its rise
    next_st.prev_lvl = lvl;
    next_st.msg.level = lvl;
    next_st.msg.intx[0] = st.ctrl[CTRL_INT_INTX] && (lvl[0] != st.prev_lvl[0]);
    next_st.msg.intx[1] = st.ctrl[CTRL_EXT_INTX] && (lvl[1] != st.prev_lvl[1]);
    next_st.msg.msi[0] = st.ctrl[CTRL_INT_MSI] && lvl[0] && !st.prev_lvl[0];
    next_st.msg.msi[1] = st.ctrl[CTRL_EXT_MSI] && lvl[1] && !st.prev_lvl[1];

    // ****************************************************************
    // Window claim check; lowest window wins
    // ****************************************************************
    // Claims past the limit become Unsupported Requests
    next_st.chk_done = chk_valid;
    next_st.chk_res = '0;
    if (chk_valid) begin
      for (int w = 0; w < NUM_WIN; w++) begin
        ev = win_eval(st, chk_req.side, w, chk_req.addr);
        if (ev[1] && !found) begin
          found = 1'b1;
          next_st.chk_res.claim = 1'b1;
          next_st.chk_res.window = 3'(w);
          next_st.chk_res.forward = ev[0];
          next_st.chk_res.ur = !ev[0];
          next_st.chk_res.lut = !chk_req.side && (w == 3);
        end
      end
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
      st.mask <= {MASK_RST, MASK_RST};
      st.ctrl <= CTRL_RST;
      // Both fixed CSR windows of the external side start enabled
      st.setup[1][0] <= SETUP_CSR_RST;
      st.setup[1][1] <= SETUP_CSR_RST;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  always_comb begin
    s_axi_awready = !st.aw_got && !st.bvalid;
    s_axi_wready = !st.w_got && !st.bvalid;
    s_axi_bvalid = st.bvalid;
    s_axi_bresp = st.bresp;
    s_axi_arready = !st.rvalid;
    s_axi_rvalid = st.rvalid;
    s_axi_rdata = st.rdata;
    s_axi_rresp = st.rresp;
    internal_irq = lvl[0];
    external_irq = lvl[1];
    irq_msg = st.msg;
    chk_done = st.chk_done;
    chk_res = st.chk_res;
  end

endmodule
`default_nettype wire

// ===== hw/ibdsw_pkg.sv
`default_nettype none
package ibdsw_pkg;

  // ****************************************************************
  // Bus geometry
  // ****************************************************************
  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;
  localparam int NUM_SCRATCH = 8;
  localparam int DB_W = 16;
  localparam int NUM_WIN = 6;

  // ****************************************************************
  // Register offsets (bit 9 of the address selects the viewing side)
  // ****************************************************************
  localparam logic [ADDR_W-1:0] OFS_SCRATCH = 10'h000;
  localparam logic [ADDR_W-1:0] OFS_INT_REQ_SET = 10'h020;
  localparam logic [ADDR_W-1:0] OFS_INT_REQ_CLR = 10'h024;
  localparam logic [ADDR_W-1:0] OFS_INT_MASK_SET = 10'h028;
  localparam logic [ADDR_W-1:0] OFS_INT_MASK_CLR = 10'h02C;
  localparam logic [ADDR_W-1:0] OFS_EXT_REQ_SET = 10'h030;
  localparam logic [ADDR_W-1:0] OFS_EXT_REQ_CLR = 10'h034;
  localparam logic [ADDR_W-1:0] OFS_EXT_MASK_SET = 10'h038;
  localparam logic [ADDR_W-1:0] OFS_EXT_MASK_CLR = 10'h03C;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 10'h040;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 10'h044;
  // Window block: 0x100 + side*0x80 + window*0x10 + {setup 0, base 4, limit 8}
  localparam logic [ADDR_W-1:0] OFS_WIN = 10'h100;
  localparam int VIEW_BIT = 9;
  localparam int WIN_BLK_BIT = 8;
  localparam int WIN_SIDE_BIT = 7;
  localparam int WIN_IDX_LSB = 4;
  localparam logic [1:0] WIN_WORD_SETUP = 2'h0;
  localparam logic [1:0] WIN_WORD_BASE = 2'h1;
  localparam logic [1:0] WIN_WORD_LIMIT = 2'h2;

  // ****************************************************************
  // Fields
  // ****************************************************************
  localparam int CTRL_INT_INTX = 0;
  localparam int CTRL_INT_MSI = 1;
  localparam int CTRL_EXT_INTX = 2;
  localparam int CTRL_EXT_MSI = 3;
  localparam logic [DATA_W-1:0] CTRL_IMPL = 32'h0000_000F;
  localparam int STAT_INT_LVL = 0;
  localparam int STAT_EXT_LVL = 1;
  localparam int STAT_LINK_UP = 2;
  localparam int SETUP_EN = 0;
  localparam int SETUP_64 = 1;
  localparam int SETUP_LIM = 2;
  localparam int SETUP_SZ_LSB = 8;
  localparam int SETUP_SZ_W = 5;
  localparam logic [SETUP_SZ_W-1:0] CSR_WIN_LOG2 = 5'h0C;

  // ****************************************************************
  // Reset values and bus answers
  // ****************************************************************
  localparam logic [DB_W-1:0] MASK_RST = 16'hFFFF;
  localparam logic [DATA_W-1:0] CTRL_RST = 32'h0000_0000;
  localparam logic [DATA_W-1:0] SETUP_CSR_RST = 32'h0000_0001;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic side;
    logic [63:0] addr;
  } ibdsw_chk_req_t;

  typedef struct packed {
    logic claim;
    logic forward;
    logic ur;
    logic lut;
    logic [2:0] window;
  } ibdsw_chk_res_t;

  typedef struct packed {
    logic [1:0] intx;
    logic [1:0] msi;
    logic [1:0] level;
  } ibdsw_msg_t;

  typedef struct packed {
    logic [NUM_SCRATCH-1:0][DATA_W-1:0] scratch;
    logic [1:0][DB_W-1:0] req;
    logic [1:0][DB_W-1:0] mask;
    logic [DATA_W-1:0] ctrl;
    logic [1:0][NUM_WIN-1:0][DATA_W-1:0] setup;
    logic [1:0][NUM_WIN-1:0][DATA_W-1:0] base;
    logic [1:0][NUM_WIN-1:0][DATA_W-1:0] limit;
    logic [2:0] lsync;
    logic link_up;
    logic aw_got;
    logic w_got;
    logic [ADDR_W-1:0] awaddr;
    logic [DATA_W-1:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
    logic [1:0] prev_lvl;
    ibdsw_msg_t msg;
    logic chk_done;
    ibdsw_chk_res_t chk_res;
  } ibdsw_state_t;

endpackage
`default_nettype wire

// ===== tb/ibdsw_far_host.sv
`timescale 1ns/1ps
`default_nettype none
module ibdsw_far_host (
  input wire logic aclk,
  output logic far_link_up,
  output logic chk_valid,
  output ibdsw_pkg::ibdsw_chk_req_t chk_req
);
  import ibdsw_pkg::*;
  initial begin
    far_link_up = 1'b0;
    chk_valid = 1'b0;
    chk_req = '0;
  end
  // Link state of the far device, then a settle span for the synchroniser
  task automatic link(input logic up);
    @(posedge aclk);
    far_link_up <= up;
    repeat (8) @(posedge aclk);
  endtask
  // One-cycle window probe; released request lines show the inverse
  task automatic probe(input logic side, input logic [63:0] addr);
    @(posedge aclk);
    chk_valid <= 1'b1;
    chk_req <= {side, addr};
    @(posedge aclk);
    chk_valid <= 1'b0;
    chk_req <= {~side, ~addr};
  endtask
endmodule
`default_nettype wire

// ===== tb/ibdsw_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module ibdsw_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ibdsw_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic far_link_up,
  input wire logic internal_irq,
  input wire logic external_irq,
  input wire ibdsw_pkg::ibdsw_msg_t irq_msg,
  input wire ibdsw_pkg::ibdsw_chk_req_t chk_req,
  input wire logic chk_done,
  input wire ibdsw_pkg::ibdsw_chk_res_t chk_res
);
  import ibdsw_pkg::*;
  logic [ADDR_W-1:0] last_aw;
  logic [1:0] lvl;
  assign lvl = {external_irq, internal_irq};
  always_ff @(posedge aclk) begin
    if (s_axi_awvalid && s_axi_awready) begin
      last_aw <= s_axi_awaddr;
    end
  end
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  irq_level_a:
    assert property (irq_msg.level == $past(lvl)) else $error("level copy wrong");
  intx_edge_a:
    assert property (irq_msg.intx[0] |-> $changed(irq_msg.level[0])) else $error("stray intx");
  msi_rise_a:
    assert property (irq_msg.msi[1] |-> $rose(irq_msg.level[1])) else $error("stray msi");
  link_off_a:
    assert property (!far_link_up [*6] |-> !internal_irq) else $error("irq with link down");
  scratch_quiet_a:
    assert property ($rose(s_axi_bvalid) && last_aw[8:5] == 4'h0 |-> $stable(lvl))
      else $error("scratch write moved irq");
  write_answer_a:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid) else $error("late write answer");
  read_answer_a:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("late read");
  fwd_or_ur_a:
    assert property (chk_done && chk_res.claim |-> chk_res.forward ^ chk_res.ur)
      else $error("forward and ur clash");
  internal_low_a:
    assert property (chk_done && !$past(chk_req.side) |-> !chk_res.claim || chk_res.window > 3'd1)
      else $error("reserved window claimed");
  lut_window_a:
    assert property (chk_done |-> chk_res.lut ==
      (chk_res.claim && !$past(chk_req.side) && chk_res.window == 3'd3)) else $error("lut flag");
  odd_alone_a:
    assert property (chk_done && chk_res.claim |-> chk_res.window != 3'd5 &&
      !($past(chk_req.side) && chk_res.window == 3'd3)) else $error("odd window claimed");
endmodule
bind ibdsw_top ibdsw_asserts u_chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .far_link_up(far_link_up), .internal_irq(internal_irq), .external_irq(external_irq),
  .irq_msg(irq_msg), .chk_req(chk_req), .chk_done(chk_done), .chk_res(chk_res));
`default_nettype wire

// ===== tb/ibdsw_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module ibdsw_tb_top;
  import ibdsw_pkg::*;
  logic aclk, aresetn, far_link_up, chk_valid, chk_done, internal_irq, external_irq;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, lv;
  ibdsw_msg_t irq_msg;
  ibdsw_chk_req_t chk_req;
  ibdsw_chk_res_t chk_res;
  int mismatches, n_compared, n_intx, n_msi, n_bad;
  assign lv = {external_irq, internal_irq};
  ibdsw_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .far_link_up(far_link_up), .internal_irq(internal_irq),
    .external_irq(external_irq), .irq_msg(irq_msg), .chk_valid(chk_valid), .chk_req(chk_req),
    .chk_done(chk_done), .chk_res(chk_res));
  ibdsw_far_host u_far (.aclk(aclk), .far_link_up(far_link_up), .chk_valid(chk_valid),
    .chk_req(chk_req));
  // ****************
  // Clock, counters and watchdog
  // ****************
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    n_intx <= n_intx + int'(irq_msg.intx[0] === 1'b1);
    n_msi <= n_msi + int'(irq_msg.msi[1] === 1'b1);
    n_bad <= n_bad + int'(irq_msg.intx[1] === 1'b1 || irq_msg.msi[0] === 1'b1);
  end
  initial begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    give_verdict();
  end
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // ****************
  // Bus and probe tasks
  // ****************
  task automatic wr(input logic [9:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    check(s_axi_bresp, er);
  endtask
  task automatic rd(input logic [9:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    check(s_axi_rdata, e);
    check(s_axi_rresp, er);
  endtask
  function automatic logic [9:0] wa(input int side, input int w, input int word);
    return 10'(32'h100 + side * 32'h80 + w * 32'h10 + word * 4);
  endfunction
  task automatic pr(input logic side, input logic [63:0] a, input logic [6:0] e);
    u_far.probe(side, a);
    @(negedge aclk);
    check({chk_done, chk_res}, {1'b1, e});
  endtask
  // ****************
  // Tests
  // ****************
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    {mismatches, n_compared, n_intx, n_msi, n_bad} = '0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(10'h028, 32'h0000_FFFF);
    rd(10'h038, 32'h0000_FFFF);
    rd(10'h240, CTRL_RST);
    rd(10'h044, 32'h0000_0000);
    rd(wa(1, 1, 0), 32'h0000_0001);
    for (int i = 0; i < 8; i++) wr(10'(i * 4), 32'hA5A5_0000 + i);
    for (int i = 0; i < 8; i++) rd(10'(32'h200 + i * 4), 32'hA5A5_0000 + i);
    u_far.link(1'b1);
    wr(10'h040, 32'h0000_0019);
    for (int s = 0; s < 2; s++) begin
      wr(10'(32'h20 + s * 16), 32'h0000_0008);
      check(lv[s], 1'b0);
      rd(10'(32'h24 + s * 16), 32'h0000_0008);
      wr(10'(32'h2C + s * 16), 32'h0000_0008);
      check(lv[s], 1'b1);
      rd(10'(32'h28 + s * 16), 32'h0000_FFF7);
      wr(10'h01C, 32'h0000_1234);
      check(lv[s], 1'b1);
      wr(10'(32'h24 + s * 16), 32'h0000_0008);
      check(lv[s], 1'b0);
    end
    repeat (3) @(posedge aclk);
    check(n_intx, 2);
    check(n_msi, 1);
    check(n_bad, 0);
    wr(10'h220, 32'h0000_0001);
    wr(10'h02C, 32'h0000_0001);
    check(internal_irq, 1'b1);
    u_far.link(1'b0);
    check(internal_irq, 1'b0);
    u_far.link(1'b1);
    check(internal_irq, 1'b1);
    wr(wa(0, 2, 0), 32'h0000_1001);
    wr(wa(0, 2, 1), 32'h5F00_0000);
    pr(1'b0, 64'h5F00_0080, 7'h62);
    wr(wa(0, 0, 0), 32'h0000_1001);
    wr(wa(0, 0, 1), 32'hA000_0000);
    pr(1'b0, 64'hA000_0010, 7'h00);
    wr(wa(0, 3, 0), 32'h0000_1005);
    wr(wa(0, 3, 1), 32'h6000_0000);
    wr(wa(0, 3, 2), 32'h6000_0FFF);
    pr(1'b0, 64'h6000_0800, 7'h6B);
    pr(1'b0, 64'h6000_2000, 7'h5B);
    wr(wa(1, 2, 0), 32'h0000_1003);
    wr(wa(1, 2, 1), 32'h7000_0000);
    wr(wa(1, 3, 1), 32'h0000_0001);
    pr(1'b1, 64'h0000_0001_7000_0010, 7'h62);
    pr(1'b1, 64'h0000_0000_7000_0010, 7'h00);
    wr(wa(1, 0, 1), 32'h8000_0000);
    wr(wa(1, 1, 1), 32'h9000_0000);
    wr(wa(1, 0, 0), 32'h0000_0000);
    pr(1'b1, 64'h8000_0100, 7'h60);
    pr(1'b1, 64'h9000_0100, 7'h61);
    wr(wa(1, 1, 0), 32'h0000_0000);
    pr(1'b1, 64'h9000_0100, 7'h00);
    wr(10'h0F0, 32'h0000_0001, RESP_SLVERR);
    rd(wa(0, 6, 0), 32'h0000_0000, RESP_SLVERR);
    give_verdict();
  end
endmodule
`default_nettype wire
